/* logic/speed_feedback_slip_correction.sv */
// Speed feedback and slip correction: AHB-Lite registers, slip
// commissioning, slip compensation, encoder decode, deadband, simulator.
// Assumes encoder pins are asynchronous; other inputs are on clk.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module speed_feedback_slip_correction #(
	parameter int POS_W    = 32,
	parameter int LOSS_CYC = sfb_pkg::ENC_LOSS_CYC
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Register bus
	input  sfb_pkg::ahb_req_t      ahb_i,
	input  wire logic              hready,
	output sfb_pkg::ahb_rsp_t      ahb_o,
	// Encoder pins
	input  sfb_pkg::enc_pins_t     enc_i,
	// Drive references, centi-hertz and centi-amps
	input  wire logic [15:0]       freq_ref,
	input  wire logic [15:0]       speed_ref,
	input  wire logic signed [15:0] torque_current,
	// Results
	output logic [15:0]            freq_out,
	output logic [15:0]            slip_freq,
	output logic                   speed_reg_clamp,
	output logic                   torque_reg_clamp,
	output logic                   power_stage_en,
	output logic                   enc_loss,
	output logic [POS_W-1:0]       position
);
	typedef enum {C_IDLE, C_POLES, C_SYNC, C_IQ} comm_t;

	sfb_pkg::ctrl_t   ctrl_ff;
	logic [15:0]      rated_slip_ff, ppr_ff, np_rpm_ff, np_freq_ff;
	logic [15:0]      np_curr_ff, np_volt_ff, np_power_ff, flux_tune_ff;
	logic [3:0]       gain_ff;
	logic             wr_pend_ff;
	logic [7:0]       wr_addr_ff;
	logic [31:0]      rdata_ff, rd_mux;
	logic             addr_ok, wr_go, cmd_go, loss_clr;
	comm_t            comm_ff;
	logic [3:0]       pp_ff;
	logic [15:0]      slip_calc_ff, flux_def_ff;
	logic             slip_load_ff;
	logic             d0_start, d0_done, d1_done, d1_busy;
	logic [31:0]      d0_dvd, d0_dvs, d0_quo, d1_quo;
	logic [31:0]      sync_60f;
	sfb_pkg::enc_pins_t s1_ff, s2_ff, prev_ff;
	logic             step, up, sgl_edge;
	logic [POS_W-1:0] pos_ff;
	logic [17:0]      rev_acc_ff;
	logic [15:0]      revs_ff;
	logic [23:0]      sim_acc_ff;
	logic [24:0]      sim_sum;
	logic             loss_cond, loss_ff;
	logic [15:0]      loss_cnt_ff;
	logic [15:0]      slip_chz_ff, flux_est, iq_eff;
	logic [31:0]      slip_gain_ff;
	logic signed [23:0] filt_ff, filt_diff;
	logic [15:0]      iq_pos;
	logic [47:0]      slip_prod;
	logic [15:0]      slip_add;
	logic [16:0]      freq_sum;
	logic [15:0]      freq_out_ff, slip_disp_ff;
	logic             clamp_ff, pwr_en_ff;
	logic [30:0]      chz_prod;

	// ********************************
	// AHB-Lite slave
	// ********************************

	// Zero wait states; every transfer answers OKAY
	assign addr_ok  = ahb_i.hsel && ahb_i.htrans[1] && hready;
	assign wr_go    = wr_pend_ff;
	assign cmd_go   = wr_go && wr_addr_ff == sfb_pkg::REG_CMD && ahb_i.hwdata[0];
	assign loss_clr = wr_go && wr_addr_ff == sfb_pkg::REG_STATUS && ahb_i.hwdata[0];

	// Address phase capture; upper address bits must be zero to hit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			rdata_ff   <= 32'h0000_0000;
		end else begin
			wr_pend_ff <= addr_ok && ahb_i.hwrite && ahb_i.haddr[31:8] == 24'h00_0000;
			wr_addr_ff <= ahb_i.haddr[7:0];
			if (addr_ok && !ahb_i.hwrite) begin
				rdata_ff <= (ahb_i.haddr[31:8] == 24'h00_0000) ? rd_mux : 32'h0000_0000;
			end
		end
	end

	// Read decode; unmapped offsets read zero
	always_comb begin
		case (ahb_i.haddr[7:0])
			sfb_pkg::REG_CTRL:       rd_mux = {16'h0000, ctrl_ff};
			sfb_pkg::REG_CMD:        rd_mux = {31'h0, comm_ff != C_IDLE};
			sfb_pkg::REG_RATED_SLIP: rd_mux = {16'h0000, rated_slip_ff};
			sfb_pkg::REG_PPR:        rd_mux = {16'h0000, ppr_ff};
			sfb_pkg::REG_SLIP_GAIN:  rd_mux = {28'h0, gain_ff};
			sfb_pkg::REG_NP_RPM:     rd_mux = {16'h0000, np_rpm_ff};
			sfb_pkg::REG_NP_FREQ:    rd_mux = {16'h0000, np_freq_ff};
			sfb_pkg::REG_NP_CURR:    rd_mux = {16'h0000, np_curr_ff};
			sfb_pkg::REG_NP_VOLT:    rd_mux = {16'h0000, np_volt_ff};
			sfb_pkg::REG_NP_POWER:   rd_mux = {16'h0000, np_power_ff};
			sfb_pkg::REG_FLUX_TUNE:  rd_mux = {16'h0000, flux_tune_ff};
			sfb_pkg::REG_STATUS:     rd_mux = {28'h0, !pwr_en_ff, clamp_ff,
			                                   comm_ff != C_IDLE, loss_ff};
			sfb_pkg::REG_POSITION:   rd_mux = 32'(pos_ff);
			sfb_pkg::REG_SLIP_FREQ:  rd_mux = {16'h0000, slip_disp_ff};
			sfb_pkg::REG_FREQ_OUT:   rd_mux = {16'h0000, freq_out_ff};
			sfb_pkg::REG_POLE_PAIRS: rd_mux = {28'h0, pp_ff};
			sfb_pkg::REG_REVS:       rd_mux = {16'h0000, revs_ff};
			default:                 rd_mux = 32'h0000_0000;
		endcase
	end

	// Software-written settings; commissioning result lands last
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_ff       <= sfb_pkg::CTRL_RST;
			rated_slip_ff <= sfb_pkg::RATED_SLIP_RST;
			ppr_ff        <= sfb_pkg::PPR_RST;
			gain_ff       <= sfb_pkg::GAIN_RST;
			np_rpm_ff     <= sfb_pkg::NP_RPM_RST;
			np_freq_ff    <= sfb_pkg::NP_FREQ_RST;
			np_curr_ff    <= sfb_pkg::NP_CURR_RST;
			np_volt_ff    <= sfb_pkg::NP_VOLT_RST;
			np_power_ff   <= sfb_pkg::NP_POWER_RST;
			flux_tune_ff  <= sfb_pkg::FLUX_TUNE_RST;
		end else begin
			if (wr_go) begin
				case (wr_addr_ff)
					sfb_pkg::REG_CTRL:       ctrl_ff       <= {6'h00, ahb_i.hwdata[9:0]};
					sfb_pkg::REG_RATED_SLIP: rated_slip_ff <= ahb_i.hwdata[15:0];
					sfb_pkg::REG_PPR:        ppr_ff        <= ahb_i.hwdata[15:0];
					sfb_pkg::REG_SLIP_GAIN:  gain_ff       <= ahb_i.hwdata[3:0];
					sfb_pkg::REG_NP_RPM:     np_rpm_ff     <= ahb_i.hwdata[15:0];
					sfb_pkg::REG_NP_FREQ:    np_freq_ff    <= ahb_i.hwdata[15:0];
					sfb_pkg::REG_NP_CURR:    np_curr_ff    <= ahb_i.hwdata[15:0];
					sfb_pkg::REG_NP_VOLT:    np_volt_ff    <= ahb_i.hwdata[15:0];
					sfb_pkg::REG_NP_POWER:   np_power_ff   <= ahb_i.hwdata[15:0];
					sfb_pkg::REG_FLUX_TUNE:  flux_tune_ff  <= ahb_i.hwdata[15:0];
					default: ;
				endcase
			end
			if (slip_load_ff) begin
				rated_slip_ff <= slip_calc_ff;
			end
		end
	end

	// ********************************
	// Commissioning
	// ********************************

	// Largest pole pair count whose sync speed still reaches nameplate rpm
	assign sync_60f = 32'(np_freq_ff) * 32'(sfb_pkg::SEC_PER_MIN);

	// Divider feed per commissioning step
	always_comb begin
		d0_start = 1'b0;
		d0_dvd   = sync_60f;
		d0_dvs   = {28'h0, pp_ff};
		case (comm_ff)
			C_POLES: d0_start = !(sync_60f >= 32'(np_rpm_ff) * 32'(pp_ff + 4'h1) &&
			                      pp_ff < sfb_pkg::MAX_POLE_PAIRS);
			C_SYNC: begin
				d0_start = d0_done;
				d0_dvd   = 32'(np_power_ff) * 32'(sfb_pkg::IQ_SCALE);
				d0_dvs   = {16'h0000, np_volt_ff};
			end
			default: ;
		endcase
	end

	// Slip = sync speed - nameplate speed; rated torque current from power
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			comm_ff      <= C_IDLE;
			pp_ff        <= 4'h2;
			slip_calc_ff <= 16'h0000;
			flux_def_ff  <= 16'h0000;
			slip_load_ff <= 1'b0;
		end else begin
			slip_load_ff <= 1'b0;
			case (comm_ff)
				C_IDLE: if (cmd_go) begin
					pp_ff   <= 4'h1;
					comm_ff <= C_POLES;
				end
				C_POLES: if (d0_start) begin
					comm_ff <= C_SYNC;
				end else begin
					pp_ff <= pp_ff + 4'h1;
				end
				C_SYNC: if (d0_done) begin
					slip_calc_ff <= (d0_quo[15:0] > np_rpm_ff) ?
					                d0_quo[15:0] - np_rpm_ff : 16'h0000;
					comm_ff      <= C_IQ;
				end
				C_IQ: if (d0_done) begin
					flux_def_ff  <= (np_curr_ff > d0_quo[15:0]) ?
					                np_curr_ff - d0_quo[15:0] : np_curr_ff >> 2;
					slip_load_ff <= 1'b1;
					comm_ff      <= C_IDLE;
				end
				default: comm_ff <= C_IDLE;
			endcase
		end
	end

	seq_divider #(.W(32)) u_comm_div (
		.clk      (clk),
		.rst      (rst),
		.start    (d0_start),
		.dividend (d0_dvd),
		.divisor  (d0_dvs),
		.busy     (),
		.done     (d0_done),
		.quotient (d0_quo)
	);

	// ********************************
	// Slip compensation
	// ********************************

	// Flux estimate from nameplate default or auto-tune
	assign flux_est = ctrl_ff.flux_tune_sel ? flux_tune_ff : flux_def_ff;
	assign iq_eff   = (np_curr_ff > flux_est) ? np_curr_ff - flux_est : 16'h0001;
	assign chz_prod = 31'(rated_slip_ff * pp_ff) * 31'(sfb_pkg::RPM_TO_CHZ_NUM);

	// Rated slip in centi-hertz per centi-amp of torque current, refreshed
	// continuously so a new setting takes effect within two divides
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			slip_chz_ff  <= 16'h0000;
			slip_gain_ff <= 32'h0000_0000;
		end else begin
			slip_chz_ff <= 16'(chz_prod >> sfb_pkg::RPM_TO_CHZ_SH);
			if (d1_done) begin
				slip_gain_ff <= d1_quo;
			end
		end
	end

	seq_divider #(.W(32)) u_slip_div (
		.clk      (clk),
		.rst      (rst),
		.start    (!d1_busy),
		.dividend ({4'h0, slip_chz_ff, 12'h000}),
		.divisor  ({16'h0000, iq_eff}),
		.busy     (d1_busy),
		.done     (d1_done),
		.quotient (d1_quo)
	);

	// First-order filter; gain 0 passes torque current straight through.
	// Eight fraction bits let it settle all the way to zero.
	assign filt_diff = {torque_current, 8'h00} - filt_ff;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			filt_ff <= 24'sh000000;
		end else begin
			filt_ff <= filt_ff + (filt_diff >>> gain_ff);
		end
	end

	// Only motoring load adds slip: the increment is never negative
	assign iq_pos    = filt_ff[23] ? 16'h0000 : filt_ff[23:8];
	assign slip_prod = 48'(slip_gain_ff) * 48'(iq_pos);
	assign slip_add  = (|slip_prod[47:28]) ? 16'hffff : slip_prod[27:12];
	assign freq_sum  = {1'b0, freq_ref} + {1'b0, slip_add};

	// Output frequency by speed mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			freq_out_ff  <= 16'h0000;
			slip_disp_ff <= 16'h0000;
		end else begin
			if (ctrl_ff.speed_mode == sfb_pkg::MODE_SLIP) begin
				freq_out_ff  <= freq_sum[16] ? 16'hffff : freq_sum[15:0];
				slip_disp_ff <= slip_add;
			end else begin
				freq_out_ff  <= freq_ref;
				slip_disp_ff <= 16'h0000;
			end
		end
	end

	// ********************************
	// Deadband and simulator
	// ********************************

	// Power stage stays off while simulating: no motor may be driven
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clamp_ff  <= 1'b0;
			pwr_en_ff <= 1'b0;
		end else begin
			clamp_ff  <= ctrl_ff.deadband_en && speed_ref < sfb_pkg::DEADBAND_CHZ;
			pwr_en_ff <= ctrl_ff.fdbk_source != sfb_pkg::SRC_SIM;
		end
	end

	// ********************************
	// Encoder feedback
	// ********************************

	// Two-stage synchroniser, then one stage of history
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_ff   <= '0;
			s2_ff   <= '0;
			prev_ff <= '0;
		end else begin
			s1_ff   <= enc_i;
			s2_ff   <= s1_ff;
			prev_ff <= s2_ff;
		end
	end

	// One channel changing at a time; a double jump is dropped
	assign step     = (s2_ff.a ^ prev_ff.a) ^ (s2_ff.b ^ prev_ff.b);
	assign up       = prev_ff.a ^ s2_ff.b;
	assign sgl_edge = s2_ff.a && !prev_ff.a;
	assign sim_sum  = {1'b0, sim_acc_ff} + {9'h000, freq_out_ff};

	// Raw count, free running modulo its width
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pos_ff     <= '0;
			sim_acc_ff <= 24'h000000;
		end else begin
			sim_acc_ff <= (ctrl_ff.fdbk_source == sfb_pkg::SRC_SIM) ? sim_sum[23:0] : 24'h000000;
			if (ctrl_ff.fdbk_source == sfb_pkg::SRC_SIM) begin
				pos_ff <= pos_ff + POS_W'(sim_sum[24]);
			end else if (!ctrl_ff.fdbk_type[1]) begin
				if (step) begin
					pos_ff <= up ? pos_ff + 1'b1 : pos_ff - 1'b1;
				end
			end else if (sgl_edge) begin
				pos_ff <= pos_ff + 1'b1;
			end
		end
	end

	// Revolutions: forward counts per turn are ppr, or four times in quadrature
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rev_acc_ff <= 18'h00000;
			revs_ff    <= 16'h0000;
		end else if (ctrl_ff.fdbk_source != sfb_pkg::SRC_SIM &&
		             (ctrl_ff.fdbk_type[1] ? sgl_edge : step && up)) begin
			if (rev_acc_ff + 18'h00001 >= (ctrl_ff.fdbk_type[1] ? {2'h0, ppr_ff}
			                                                  : {ppr_ff, 2'h0})) begin
				rev_acc_ff <= 18'h00000;
				revs_ff    <= revs_ff + 16'h0001;
			end else begin
				rev_acc_ff <= rev_acc_ff + 18'h00001;
			end
		end
	end

	// Complementary pair at equal level means a broken line
	assign loss_cond = ctrl_ff.fdbk_type[0] && ctrl_ff.diff_inputs &&
	                   (s2_ff.a == s2_ff.a_n ||
	                    (!ctrl_ff.fdbk_type[1] && s2_ff.b == s2_ff.b_n));

	// Loss must persist to filter crossover glitches; set beats clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			loss_cnt_ff <= 16'h0000;
			loss_ff     <= 1'b0;
		end else begin
			loss_cnt_ff <= !loss_cond ? 16'h0000 :
			               (loss_cnt_ff == 16'(LOSS_CYC)) ? loss_cnt_ff : loss_cnt_ff + 16'h0001;
			if (loss_cond && loss_cnt_ff == 16'(LOSS_CYC - 1)) begin
				loss_ff <= 1'b1;
			end else if (loss_clr) begin
				loss_ff <= 1'b0;
			end
		end
	end

	// ********************************
	// Outputs
	// ********************************
	assign ahb_o.hreadyout = 1'b1;
	assign ahb_o.hresp     = 1'b0;
	assign ahb_o.hrdata    = rdata_ff;
	assign freq_out        = freq_out_ff;
	assign slip_freq       = slip_disp_ff;
	assign speed_reg_clamp  = clamp_ff;
	assign torque_reg_clamp = clamp_ff;
	assign power_stage_en  = pwr_en_ff;
	assign enc_loss        = loss_ff;
	assign position        = pos_ff;

endmodule : speed_feedback_slip_correction

/* logic/sfb_pkg.sv */
// Register map, reset values, timing counts and carrier types of the
// speed feedback and slip correction block.
// Assumes a 10 MHz clock and an AHB-Lite master doing word transfers.
package sfb_pkg;

	// ********************************
	// Register byte offsets
	// ********************************
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_CMD        = 8'h04;
	localparam logic [7:0] REG_RATED_SLIP = 8'h08;
	localparam logic [7:0] REG_PPR        = 8'h0c;
	localparam logic [7:0] REG_SLIP_GAIN  = 8'h10;
	localparam logic [7:0] REG_NP_RPM     = 8'h14;
	localparam logic [7:0] REG_NP_FREQ    = 8'h18;
	localparam logic [7:0] REG_NP_CURR    = 8'h1c;
	localparam logic [7:0] REG_NP_VOLT    = 8'h20;
	localparam logic [7:0] REG_NP_POWER   = 8'h24;
	localparam logic [7:0] REG_FLUX_TUNE  = 8'h28;
	localparam logic [7:0] REG_STATUS     = 8'h2c;
	localparam logic [7:0] REG_POSITION   = 8'h30;
	localparam logic [7:0] REG_SLIP_FREQ  = 8'h34;
	localparam logic [7:0] REG_FREQ_OUT   = 8'h38;
	localparam logic [7:0] REG_POLE_PAIRS = 8'h3c;
	localparam logic [7:0] REG_REVS       = 8'h40;

	// ********************************
	// Mode codes
	// ********************************
	localparam logic [1:0] MODE_OPEN    = 2'h0;
	localparam logic [1:0] MODE_SLIP    = 2'h1;
	localparam logic [1:0] MODE_PROCESS = 2'h2;
	localparam logic [2:0] SRC_ENCODER  = 3'h3;
	localparam logic [2:0] SRC_SIM      = 3'h5;
	localparam logic [1:0] TYPE_QUAD    = 2'h0;
	localparam logic [1:0] TYPE_QUAD_CK = 2'h1;
	localparam logic [1:0] TYPE_SGL     = 2'h2;
	localparam logic [1:0] TYPE_SGL_CK  = 2'h3;

	// ********************************
	// Reset values
	// ********************************
	localparam logic [15:0] CTRL_RST       = 16'h0000;
	localparam logic [15:0] RATED_SLIP_RST = 16'h0032;
	localparam logic [15:0] PPR_RST        = 16'h0400;
	localparam logic [3:0]  GAIN_RST       = 4'h4;
	localparam logic [15:0] NP_RPM_RST     = 16'h06d6;
	localparam logic [15:0] NP_FREQ_RST    = 16'h003c;
	localparam logic [15:0] NP_CURR_RST    = 16'h03e8;
	localparam logic [15:0] NP_VOLT_RST    = 16'h01e0;
	localparam logic [15:0] NP_POWER_RST   = 16'h1d4c;
	localparam logic [15:0] FLUX_TUNE_RST  = 16'h0190;

	// ********************************
	// Scaling and timing
	// ********************************
	localparam logic [15:0] SEC_PER_MIN    = 16'h003c;
	localparam logic [10:0] RPM_TO_CHZ_NUM = 11'h6ab;
	localparam int          RPM_TO_CHZ_SH  = 10;
	localparam logic [7:0]  IQ_SCALE       = 8'h3a;
	localparam int          GAIN_FRAC      = 12;
	localparam logic [3:0]  MAX_POLE_PAIRS = 4'hf;
	localparam logic [15:0] DEADBAND_CHZ   = 16'h0032;
	localparam int          CLK_MHZ        = 10;
	localparam int          ENC_LOSS_US    = 10;
	localparam int          ENC_LOSS_CYC   = ENC_LOSS_US * CLK_MHZ;

	// ********************************
	// Carrier types
	// ********************************
	typedef struct packed {
		logic [5:0] rsvd;
		logic       flux_tune_sel;
		logic       deadband_en;
		logic       diff_inputs;
		logic [1:0] fdbk_type;
		logic [2:0] fdbk_source;
		logic [1:0] speed_mode;
	} ctrl_t;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
	} ahb_req_t;

	typedef struct packed {
		logic        hreadyout;
		logic        hresp;
		logic [31:0] hrdata;
	} ahb_rsp_t;

	typedef struct packed {
		logic a;
		logic a_n;
		logic b;
		logic b_n;
	} enc_pins_t;

endpackage : sfb_pkg

/* logic/seq_divider.sv */
// Restoring unsigned divider, one quotient bit per clock.
// Assumes start is only raised while busy is low.
`timescale 1ns/1ps
module seq_divider #(
	parameter int W = 32
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Request
	input  wire logic         start,
	input  wire logic [W-1:0] dividend,
	input  wire logic [W-1:0] divisor,
	// Result
	output logic              busy,
	output logic              done,
	output logic [W-1:0]      quotient
);
	logic [W-1:0] rem_ff;
	logic [W-1:0] quo_ff;
	logic [W-1:0] dvs_ff;
	logic [7:0]   cnt_ff;
	logic         busy_ff;
	logic         done_ff;
	logic [W:0]   shifted;
	logic         ge;

	// Divide by zero yields all ones
	assign shifted = {rem_ff, quo_ff[W-1]};
	assign ge      = shifted >= {1'b0, dvs_ff};

	// Shift and subtract step
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rem_ff  <= '0;
			quo_ff  <= '0;
			dvs_ff  <= '0;
			cnt_ff  <= 8'h00;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (start && !busy_ff) begin
				rem_ff  <= '0;
				quo_ff  <= dividend;
				dvs_ff  <= divisor;
				cnt_ff  <= 8'(W);
				busy_ff <= 1'b1;
			end else if (busy_ff) begin
				rem_ff <= ge ? W'(shifted - {1'b0, dvs_ff}) : shifted[W-1:0];
				quo_ff <= {quo_ff[W-2:0], ge};
				cnt_ff <= cnt_ff - 8'h01;
				if (cnt_ff == 8'h01) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end
			end
		end
	end

	assign busy     = busy_ff;
	assign done     = done_ff;
	assign quotient = quo_ff;

endmodule : seq_divider

/* verif/sfb_enc_model.sv */
// Incremental shaft encoder on the motor, with complementary lines.
// Assumes the bench calls step just after a rising clock edge.
`timescale 1ns/1ps
module sfb_enc_model (
	// Loss request from the bench
	input  wire logic         lose,
	// Encoder pins
	output sfb_pkg::enc_pins_t pins
);
	logic a = 1'b0;
	logic b = 1'b0;

	// One edge per call; forward runs 00,01,11,10 so b leads a
	task automatic step(input int dir, input bit sgl);
		if (sgl)
			a <= ~a;
		else if ((a == b) == (dir > 0))
			b <= ~b;
		else
			a <= ~a;
	endtask : step

	// A lost cable shows equal true and inverted lines
	assign pins = '{a: a, a_n: lose ? a : ~a, b: b, b_n: lose ? b : ~b};
endmodule : sfb_enc_model

/* verif/sfb_sva.sv */
// Checker of the slip and feedback block, bound to its top ports.
// Keeps its own copy of CTRL, since the register is not a port.
`timescale 1ns/1ps
module sfb_sva #(
	parameter int POS_W    = 32,
	parameter int LOSS_CYC = 100
) (
	// Clock and reset
	input wire logic                clk,
	input wire logic                rst,
	// Bus
	input sfb_pkg::ahb_req_t        ahb_i,
	input wire logic                hready,
	input sfb_pkg::ahb_rsp_t        ahb_o,
	// Pins and references
	input sfb_pkg::enc_pins_t       enc_i,
	input wire logic [15:0]         freq_ref,
	input wire logic [15:0]         speed_ref,
	input wire logic signed [15:0]  torque_current,
	// Results
	input wire logic [15:0]         freq_out,
	input wire logic [15:0]         slip_freq,
	input wire logic                speed_reg_clamp,
	input wire logic                torque_reg_clamp,
	input wire logic                power_stage_en,
	input wire logic                enc_loss,
	input wire logic [POS_W-1:0]    position
);
	// Margin covers the pin synchronisers
	localparam int LOSS_MAX = LOSS_CYC + 6;
	logic           wr_ff;
	logic           clr_ff;
	logic [7:0]     adr_ff;
	int             run_ff;
	sfb_pkg::ctrl_t ctl_ff;

	// Shadow CTRL, W1C strobe and a count of lost-signal cycles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ff  <= 1'b0;
			clr_ff <= 1'b0;
			adr_ff <= 8'h00;
			ctl_ff <= '0;
			run_ff <= 0;
		end else begin
			wr_ff  <= hready && ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hwrite
				&& ahb_i.haddr[31:8] == 24'h000000;
			adr_ff <= ahb_i.haddr[7:0];
			clr_ff <= wr_ff && adr_ff == 8'h2c && ahb_i.hwdata[0];
			if (wr_ff && adr_ff == 8'h00)
				ctl_ff <= ahb_i.hwdata[15:0];
			if (ctl_ff.fdbk_type[0] && ctl_ff.diff_inputs && enc_i.a == enc_i.a_n)
				run_ff <= (run_ff < LOSS_MAX) ? run_ff + 1 : run_ff;
			else
				run_ff <= 0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ********************************
	// Assertions
	// ********************************
	sequence s_calm;
		(ctl_ff.speed_mode != 2'h1 && $stable(freq_ref))[*3];
	endsequence
	a_open_pass: assert property (s_calm |-> freq_out == freq_ref)
		else $error("open loop changed the frequency");
	a_slip_idle: assert property (ctl_ff.speed_mode != 2'h1 |=> slip_freq == 16'h0000)
		else $error("slip shown outside slip mode");
	a_slip_adds: assert property ((ctl_ff.speed_mode == 2'h1 && $stable(freq_ref))[*3]
		|-> freq_out >= freq_ref) else $error("slip lowered the frequency");
	a_clamp_low: assert property ({speed_reg_clamp, torque_reg_clamp} ==
		{2{$past(ctl_ff.deadband_en) && $past(speed_ref) < 16'h0032}})
		else $error("deadband clamp wrong");
	a_sim_off: assert property (ctl_ff == $past(ctl_ff) && !$past(rst)
		|-> power_stage_en == (ctl_ff.fdbk_source != 3'h5)) else $error("stage enable wrong");
	a_pos_step: assert property (position == $past(position) ||
		position == $past(position) + 1'b1 || position == $past(position) - 1'b1)
		else $error("position jumped");
	a_loss_gate: assert property ($rose(enc_loss) |->
		$past(ctl_ff.diff_inputs && ctl_ff.fdbk_type[0])) else $error("loss flagged unchecked");
	a_loss_time: assert property (run_ff == LOSS_MAX |-> enc_loss)
		else $error("loss not flagged");
	a_loss_clear: assert property ($fell(enc_loss) |-> clr_ff)
		else $error("loss flag dropped by itself");
	c_slip: cover property (slip_freq != 16'h0000);
	c_clamp: cover property ($rose(speed_reg_clamp));
	c_loss: cover property ($rose(enc_loss));
endmodule : sfb_sva

bind speed_feedback_slip_correction sfb_sva #(.POS_W(POS_W), .LOSS_CYC(LOSS_CYC)) i_sfb_sva (
	.clk(clk), .rst(rst), .ahb_i(ahb_i), .hready(hready), .ahb_o(ahb_o), .enc_i(enc_i),
	.freq_ref(freq_ref), .speed_ref(speed_ref), .torque_current(torque_current),
	.freq_out(freq_out), .slip_freq(slip_freq), .speed_reg_clamp(speed_reg_clamp),
	.torque_reg_clamp(torque_reg_clamp), .power_stage_en(power_stage_en),
	.enc_loss(enc_loss), .position(position));

/* verif/speed_feedback_slip_correction_tb_top.sv */
// Self-checking bench: registers, slip, commissioning, encoder, deadband.
// Assumes the package, design, model and checker are compiled first.
`timescale 1ns/1ps
module speed_feedback_slip_correction_tb_top;
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic               lose = 1'b0;
	sfb_pkg::ahb_req_t  rq = '0;
	sfb_pkg::ahb_rsp_t  rs;
	sfb_pkg::enc_pins_t enc;
	logic [15:0]        fr = 16'h0000;
	logic [15:0]        sr = 16'h0000;
	logic signed [15:0] tq = 16'sh0000;
	logic [15:0]        fo;
	logic [15:0]        sf;
	logic               scl;
	logic               tcl;
	logic               pse;
	logic               loss;
	logic [31:0]        pos;
	logic [31:0]        q;
	logic [31:0]        p0;
	logic [31:0]        ra [4] = '{32'h00, 32'h08, 32'h0c, 32'h100};
	logic [31:0]        rv [4] = '{32'h00, 32'h32, 32'h400, 32'h00};
	int                 fails = 0;
	int                 checks_done = 0;
	int                 cyc = 0;

	// Short loss count keeps the run brief
	speed_feedback_slip_correction #(.LOSS_CYC(4)) i_speed_feedback_slip_correction (
		.clk(clk), .rst(rst), .ahb_i(rq), .hready(rs.hreadyout), .ahb_o(rs), .enc_i(enc),
		.freq_ref(fr), .speed_ref(sr), .torque_current(tq), .freq_out(fo), .slip_freq(sf),
		.speed_reg_clamp(scl), .torque_reg_clamp(tcl), .power_stage_en(pse),
		.enc_loss(loss), .position(pos));
	sfb_enc_model i_sfb_enc_model (.lose(lose), .pins(enc));

	// Clock and hang guard
	initial forever #50 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fails++;
			finish_test();
		end
	end

	// ********************************
	// Tasks
	// ********************************
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	// One single word transfer; waits for hready in both phases
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		rq.hsel   <= 1'b1;
		rq.haddr  <= a;
		rq.htrans <= 2'h2;
		rq.hwrite <= w;
		rq.hsize  <= 3'h2;
		@(posedge clk);
		while (rs.hreadyout !== 1'b1) @(posedge clk);
		rq.htrans <= 2'h0;
		rq.hwdata <= d;
		@(posedge clk);
		while (rs.hreadyout !== 1'b1) @(posedge clk);
		q = rs.hrdata;
	endtask : bus

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// Encoder steps at a chosen pace, then lets the synchroniser settle
	task automatic spin(input int n, input int dir, input bit sgl, input int gap);
		repeat (n) begin
			i_sfb_enc_model.step(dir, sgl);
			tick(gap);
		end
		tick(6);
	endtask : spin

	task automatic finish_test();
		$display("fails=%0d checks_done=%0d", fails, checks_done);
		if (fails == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	// ********************************
	// Scenarios
	// ********************************
	initial begin
		void'($urandom(32'hd851));
		tick(12);
		rst <= 1'b0;
		tick(1);
		foreach (ra[i]) begin
			bus(1'b0, ra[i], 32'h0);
			chk(q, rv[i]);
		end
		// Each speed mode with loaded motor
		fr <= 16'($urandom_range(40000, 1000));
		tq <= 16'sh0200;
		for (int m = 0; m < 3; m++) begin
			bus(1'b1, 32'h00, 32'(m));
			tick(80);
			chk(fo, fr + sf);
			chk(sf != 16'h0, m == 1);
		end
		bus(1'b1, 32'h00, 32'h1);
		tick(80);
		p0 = 32'(sf);
		bus(1'b1, 32'h08, 32'h64);
		tick(80);
		chk(sf > p0[15:0], 1'b1);
		// Filter depth: deep filter lags, no filter follows at once
		for (int g = 15; g >= 0; g -= 15) begin
			tq <= 16'sh0000;
			tick(500);
			chk(sf, 32'h0);
			bus(1'b1, 32'h10, 32'(g));
			tq <= 16'sh0200;
			tick(4);
			chk(sf != 16'h0, g == 0);
		end
		// Commissioning from nameplate speed
		bus(1'b1, 32'h14, 32'd1700);
		bus(1'b1, 32'h04, 32'h1);
		do bus(1'b0, 32'h04, 32'h0); while (q[0] === 1'b1);
		bus(1'b0, 32'h08, 32'h0);
		chk(q, 32'(3600 / (3600 / 1700) - 1700));
		// Quadrature wraps below zero, then one turn of eight pulses
		bus(1'b1, 32'h0c, 32'h8);
		bus(1'b1, 32'h00, 32'h0c);
		spin(1, -1, 1'b0, 4);
		chk(pos, 32'hffffffff);
		spin(32, 1, 1'b0, 3);
		chk(pos, 32'd31);
		bus(1'b1, 32'h00, 32'h4c);
		spin(16, 1, 1'b1, 9);
		chk(pos, 32'd39);
		bus(1'b0, 32'h30, 32'h0);
		chk(q, 32'd39);
		// Loss only flagged with differential inputs
		lose <= 1'b1;
		bus(1'b1, 32'h00, 32'h2c);
		tick(40);
		chk(loss, 1'b0);
		bus(1'b1, 32'h00, 32'hac);
		tick(20);
		chk(loss, 1'b1);
		lose <= 1'b0;
		tick(10);
		bus(1'b1, 32'h2c, 32'h1);
		bus(1'b0, 32'h2c, 32'h0);
		chk(q[0], 1'b0);
		// Deadband below and above the threshold
		bus(1'b1, 32'h00, 32'h100);
		for (int k = 0; k < 2; k++) begin
			sr <= 16'(k ? $urandom_range(9000, 50) : $urandom_range(49, 0));
			tick(4);
			chk({scl, tcl}, k ? 2'b00 : 2'b11);
		end
		// Simulator turns the stage off and moves position
		fr <= 16'hffff;
		bus(1'b1, 32'h00, 32'h14);
		tick(4);
		chk(pse, 1'b0);
		p0 = pos;
		tick(600);
		chk(pos != p0, 1'b1);
		finish_test();
	end
endmodule : speed_feedback_slip_correction_tb_top
